// File: common/sram_tap_map.svh
`ifndef SRAM_TAP_MAP_SVH
`define SRAM_TAP_MAP_SVH
`define TAP_IR_LEN          3
`define TAP_OP_CAPTURE      3'h0
`define TAP_OP_IDCODE       3'h1
`define TAP_OP_SAMPLEZ      3'h2
`define TAP_OP_SAMPLE       3'h4
`define TAP_OP_BYPASS       3'h7
`define TAP_IR_CAPTURE_LOW  2'h1
`define TAP_RESET_TMS_RISES 5
`define TAP_BSR_LEN_X36     73
`define TAP_BSR_LEN_X18     54
`define TAP_ID_LEN          32
`define TAP_ID_PRESENT      1'h1
`define TAP_TCK_MAX_KHZ     10000
`define TAP_CORE_CLK_KHZ    10000
`endif

// File: common/sram_tap_pkg.sv
package sram_tap_pkg;
  typedef enum logic [3:0] {
    TLR   = 4'h0, RTI   = 4'h1, SELDR = 4'h3, CAPDR = 4'h2,
    SHDR  = 4'h6, EX1DR = 4'h7, PSDR  = 4'h5, EX2DR = 4'h4,
    UPDR  = 4'hc, SELIR = 4'hd, CAPIR = 4'hf, SHIR  = 4'he,
    EX1IR = 4'ha, PSIR  = 4'hb, EX2IR = 4'h9, UPIR  = 4'h8
  } tap_state_t;
  typedef logic [2:0] tap_op_t;
  typedef struct packed {
    logic drive;
    logic value;
  } tdo_word_t;
endpackage

// File: hdl/sram_boundary_scan_tap.sv
`timescale 1ns/1ps
`include "sram_tap_map.svh"
module sram_boundary_scan_tap
  import sram_tap_pkg::*;
#(
  parameter int          BSR_LEN  = `TAP_BSR_LEN_X36,
  parameter logic [2:0]  REVISION = 3'h0,
  parameter logic [16:0] ID_MID   = 17'h0_0001,
  parameter logic [10:0] VENDOR   = 11'h2a5  // arbitrary value
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // test pins
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdoOe,
  // memory ring and control
  input  wire logic [BSR_LEN-1:0] ringPins,
  output logic                    memOutHiZ
);

  localparam logic [`TAP_ID_LEN-1:0] ID_WORD = {REVISION, ID_MID, VENDOR, `TAP_ID_PRESENT};

  if (BSR_LEN != `TAP_BSR_LEN_X36 && BSR_LEN != `TAP_BSR_LEN_X18) begin : gen_len_check
    $error("boundary length must be 73 or 54");
  end
  // limitation: test clock high and low must each also last three core cycles
  if (`TAP_TCK_MAX_KHZ > `TAP_CORE_CLK_KHZ) begin : gen_clk_check
    $error("core clock too slow to sample test clock");
  end

  function automatic logic usesBsr(input tap_op_t op);
    usesBsr = (op == `TAP_OP_CAPTURE) || (op == `TAP_OP_SAMPLEZ) || (op == `TAP_OP_SAMPLE);
  endfunction

  function automatic logic floatsMem(input tap_op_t op);
    floatsMem = (op == `TAP_OP_CAPTURE) || (op == `TAP_OP_SAMPLEZ);
  endfunction

  // input synchronisers; first stage feeds only the second
  logic [1:0]         tckS;
  logic [1:0]         tmsS;
  logic [1:0]         tdiS;
  logic [BSR_LEN-1:0] ringS0;
  logic [BSR_LEN-1:0] ringS1;
  logic               tckD;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tckS   <= 2'h0;
      tmsS   <= 2'h3;
      tdiS   <= 2'h3;
      ringS0 <= '0;
      ringS1 <= '0;
      tckD   <= 1'h0;
    end else begin
      tckS   <= {tckS[0], tck};
      tmsS   <= {tmsS[0], tms};
      tdiS   <= {tdiS[0], tdi};
      ringS0 <= ringPins;
      ringS1 <= ringS0;
      tckD   <= tckS[1];
    end
  end

  logic riseEdge;
  logic fallEdge;
  assign riseEdge = tckS[1] & ~tckD;
  assign fallEdge = ~tckS[1] & tckD;

  // two-entry buffer between the shift stage and the output stage
  tdo_word_t mem [2];
  logic      wrPtr;
  logic      rdPtr;
  logic [1:0] count;
  logic      inReady;
  logic      outValid;
  logic      push;
  logic      pop;
  tdo_word_t pushWord;
  tdo_word_t next_mem [2];
  logic      next_wrPtr;
  logic      next_rdPtr;
  logic [1:0] next_count;

  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign pop      = fallEdge & outValid;

  always_comb begin
    next_mem    = mem;
    next_wrPtr  = wrPtr;
    next_rdPtr  = rdPtr;
    next_count  = count;
    if (push) begin
      next_mem[wrPtr] = pushWord;
      next_wrPtr      = ~wrPtr;
    end
    if (pop) begin
      next_rdPtr = ~rdPtr;
    end
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wrPtr  <= 1'h0;
      rdPtr  <= 1'h0;
      count  <= 2'h0;
    end else begin
      mem    <= next_mem;
      wrPtr  <= next_wrPtr;
      rdPtr  <= next_rdPtr;
      count  <= next_count;
    end
  end

  // tap state and scan registers; a rise waits while the buffer is full
  tap_state_t         state;
  tap_op_t            instr;
  logic [2:0]         irShift;
  logic               bypass;
  logic [BSR_LEN-1:0] bsr;
  logic [`TAP_ID_LEN-1:0] idReg;
  logic               risePend;
  logic [2:0]         tmsRun;
  tap_state_t         next_state;
  tap_op_t            next_instr;
  logic [2:0]         next_irShift;
  logic               next_bypass;
  logic [BSR_LEN-1:0] next_bsr;
  logic [`TAP_ID_LEN-1:0] next_idReg;
  logic               next_risePend;
  logic [2:0]         next_tmsRun;
  logic               doRise;
  logic               tmsIn;
  logic               tdiIn;

  assign tmsIn  = tmsS[1];
  assign tdiIn  = tdiS[1];
  assign doRise = (riseEdge | risePend) & inReady;
  assign push   = doRise;

  always_comb begin
    next_state    = state;
    next_instr    = instr;
    next_irShift  = irShift;
    next_bypass   = bypass;
    next_bsr      = bsr;
    next_idReg    = idReg;
    next_tmsRun   = tmsRun;
    next_risePend = (riseEdge | risePend) & ~inReady;
    pushWord      = '0;
    if (doRise) begin
      case (state)
        TLR:     next_state = tmsIn ? TLR   : RTI;
        RTI:     next_state = tmsIn ? SELDR : RTI;
        SELDR:   next_state = tmsIn ? SELIR : CAPDR;
        CAPDR:   next_state = tmsIn ? EX1DR : SHDR;
        SHDR:    next_state = tmsIn ? EX1DR : SHDR;
        EX1DR:   next_state = tmsIn ? UPDR  : PSDR;
        PSDR:    next_state = tmsIn ? EX2DR : PSDR;
        EX2DR:   next_state = tmsIn ? UPDR  : SHDR;
        UPDR:    next_state = tmsIn ? SELDR : RTI;
        SELIR:   next_state = tmsIn ? TLR   : CAPIR;
        CAPIR:   next_state = tmsIn ? EX1IR : SHIR;
        SHIR:    next_state = tmsIn ? EX1IR : SHIR;
        EX1IR:   next_state = tmsIn ? UPIR  : PSIR;
        PSIR:    next_state = tmsIn ? EX2IR : PSIR;
        EX2IR:   next_state = tmsIn ? UPIR  : SHIR;
        UPIR:    next_state = tmsIn ? SELDR : RTI;
        default: next_state = TLR;
      endcase
      next_tmsRun = tmsIn ? ((tmsRun == 3'(`TAP_RESET_TMS_RISES)) ? tmsRun : tmsRun + 3'h1)
                          : 3'h0;
      // shifts act on the state being left, captures on the state entered
      if (state == SHIR) begin
        next_irShift = {tdiIn, irShift[2:1]};
      end
      if (state == UPIR) begin
        next_instr = irShift;
      end
      if (state == SHDR) begin
        if (usesBsr(instr)) begin
          next_bsr = {tdiIn, bsr[BSR_LEN-1:1]};
        end else if (instr == `TAP_OP_IDCODE) begin
          next_idReg = {tdiIn, idReg[`TAP_ID_LEN-1:1]};
        end else begin
          next_bypass = tdiIn;
        end
      end
      // update-data drives nothing toward the memory in any mode
      if (next_state == CAPIR) begin
        next_irShift = {1'b0, `TAP_IR_CAPTURE_LOW};
      end
      if (next_state == CAPDR) begin
        if (usesBsr(instr)) begin
          next_bsr = ringS1;
        end
        next_idReg  = ID_WORD;
        next_bypass = 1'b0;
      end
      if (next_state == TLR) begin
        next_instr = `TAP_OP_IDCODE;
      end
      pushWord.drive = (next_state == SHIR) || (next_state == SHDR);
      if (next_state == SHIR) begin
        pushWord.value = next_irShift[0];
      end else if (usesBsr(next_instr)) begin
        pushWord.value = next_bsr[0];
      end else if (next_instr == `TAP_OP_IDCODE) begin
        pushWord.value = next_idReg[0];
      end else begin
        pushWord.value = next_bypass; // reserved codes fall to bypass
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= TLR;
      instr    <= `TAP_OP_IDCODE;
      irShift  <= '0;
      bypass   <= 1'h0;
      bsr      <= '0;
      idReg    <= '0;
      risePend <= 1'h0;
      tmsRun   <= 3'h0;
    end else begin
      state    <= next_state;
      instr    <= next_instr;
      irShift  <= next_irShift;
      bypass   <= next_bypass;
      bsr      <= next_bsr;
      idReg    <= next_idReg;
      risePend <= next_risePend;
      tmsRun   <= next_tmsRun;
    end
  end

  // output stage; the scan logic has no path into memory address or data, and controls the memory only through memOutHiZ
  logic next_tdo;
  logic next_tdoOe;
  logic next_memOutHiZ;

  always_comb begin
    next_tdo       = tdo;
    next_tdoOe     = tdoOe;
    next_memOutHiZ = floatsMem(instr);
    if (pop) begin
      next_tdo   = mem[rdPtr].value;
      next_tdoOe = mem[rdPtr].drive;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo       <= 1'h0;
      tdoOe     <= 1'h0;
      memOutHiZ <= 1'h0;
    end else begin
      tdo       <= next_tdo;
      tdoOe     <= next_tdoOe;
      memOutHiZ <= next_memOutHiZ;
    end
  end

  tlr_after_five_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tmsRun == 3'(`TAP_RESET_TMS_RISES)) |-> (state == TLR))
    else $error("five high mode-select rises did not reach reset");
  tdo_on_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($changed(tdo) || $changed(tdoOe)) |-> $past(fallEdge))
    else $error("serial output changed away from a falling edge");
  id_in_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TLR) |-> (instr == `TAP_OP_IDCODE))
    else $error("reset state without identification instruction");
  capir_pattern_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == CAPIR && $changed(state)) |-> (irShift[1:0] == `TAP_IR_CAPTURE_LOW))
    else $error("capture-instruction pattern missing");
  instr_update_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(instr) |-> ($past(state) == UPIR || state == TLR))
    else $error("instruction changed outside update");
  bypass_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == CAPDR && instr == `TAP_OP_BYPASS) |-> (bypass == 1'b0))
    else $error("bypass not cleared at capture");
  mem_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == RTI && floatsMem(instr)) [*2] |-> memOutHiZ)
    else $error("memory outputs not floated");
  drive_in_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(tdoOe) |-> (state == SHIR || state == SHDR))
    else $error("serial output driven outside shift");

endmodule // sram_boundary_scan_tap

// File: tb/jtag_host.sv
`timescale 1ns/1ps
module jtag_host (
  // clock
  input  wire logic core_clk,
  // test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoOe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // 800 ns period, 5 core cycles low and 3 high, mode/data held well around the rise
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    @(negedge core_clk);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (5) @(negedge core_clk);
    o = tdoOe ? tdo : ~tdo;  // a released line never shows a trustworthy value
    oe = tdoOe;
    tck = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  // from idle to the shift state, then n bits with the last one leaving shift
  task automatic scan(input logic ir, input int n, input logic [79:0] din,
                      output logic [79:0] dout, output logic oeAll);
    logic o;
    logic oe;
    dout = '0;
    oeAll = 1'b1;
    step(1'b1, 1'b1, o, oe);
    if (ir) step(1'b1, 1'b1, o, oe);
    step(1'b0, 1'b1, o, oe);
    step(1'b0, 1'b1, o, oe);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oeAll = oeAll & oe;
    end
  endtask
  // exit-1 then update then idle; oe is what the exit state shows
  task automatic finish(output logic oe);
    logic o;
    logic oe2;
    step(1'b1, 1'b1, o, oe);
    step(1'b0, 1'b1, o, oe2);
  endtask
endmodule  // jtag_host

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "sram_tap_map.svh"
module testbench
  import sram_tap_pkg::*;
;
  typedef struct packed {
    tap_op_t    op;
    logic       hiz;
    logic [1:0] kind;
  } row_t;
  localparam int          BSR  = `TAP_BSR_LEN_X36;
  localparam logic [2:0]  REV  = 3'h5;
  localparam logic [16:0] MID  = 17'h1_2345;
  localparam logic [10:0] VEND = 11'h3c6;  // arbitrary value
  localparam logic [31:0] IDW  = {REV, MID, VEND, `TAP_ID_PRESENT};
  localparam logic [79:0] DIN  = 80'hc3a5_0f1e_2d3c_4b5a_6978;
  logic           core_clk;
  logic           rst_n;
  logic           tck;
  logic           tms;
  logic           tdi;
  logic           tdo;
  logic           tdoOe;
  logic [BSR-1:0] ringPins;
  logic           memOutHiZ;
  logic [1:0]     lastOut;
  int             failures = 0;
  int             compares = 0;
  row_t rows [5] = '{'{`TAP_OP_CAPTURE, 1'b1, 2'h1}, '{`TAP_OP_IDCODE, 1'b0, 2'h0},
                     '{`TAP_OP_SAMPLEZ, 1'b1, 2'h1}, '{`TAP_OP_SAMPLE, 1'b0, 2'h1},
                     '{`TAP_OP_BYPASS, 1'b0, 2'h2}};
  sram_boundary_scan_tap #(.BSR_LEN(BSR), .REVISION(REV), .ID_MID(MID), .VENDOR(VEND)) dut_u (
    .core_clk (core_clk), .rst_n (rst_n), .tck (tck), .tms (tms), .tdi (tdi),
    .tdo (tdo), .tdoOe (tdoOe), .ringPins (ringPins), .memOutHiZ (memOutHiZ));
  jtag_host host_u (.core_clk (core_clk), .tck (tck), .tms (tms), .tdi (tdi),
                    .tdo (tdo), .tdoOe (tdoOe));
  task automatic check(input string name, input logic [79:0] exp, input logic [79:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // the serial output must stay put while the test clock is high
  always @(posedge core_clk) begin
    if (rst_n && tck) check("tdo during high", lastOut, {tdoOe, tdoOe & tdo});
    lastOut <= {tdoOe, tdoOe & tdo};
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    stop_test;
  end
  initial begin
    logic [79:0] dout;
    logic [79:0] cap;
    logic        oeAll;
    logic        oe;
    logic        o;
    int          len;
    rst_n = 1'b0;
    ringPins = 73'h0a5_6789_abcd_ef01_2345;
    repeat (3) @(negedge core_clk);
    check("tdoOe at power-up", 80'h0, tdoOe);
    rst_n = 1'b1;
    host_u.step(1'b0, 1'b1, o, oe);
    foreach (rows[r]) begin
      ringPins = {ringPins[BSR-2:0], ringPins[BSR-1]};
      host_u.scan(1'b1, 3, 80'(rows[r].op), dout, oeAll);
      check("captured ir", 80'h1, dout);
      host_u.finish(oe);
      repeat (4) @(negedge core_clk);
      check("memOutHiZ", rows[r].hiz, memOutHiZ);
      case (rows[r].kind)
        2'h0: begin len = 32; cap = 80'(IDW); end
        2'h1: begin len = BSR; cap = 80'(ringPins); end
        default: begin len = 1; cap = '0; end
      endcase
      host_u.scan(1'b0, 80, DIN, dout, oeAll);
      check("dr scan", (cap & ((80'h1 << len) - 80'h1)) | (DIN << len),
            dout);
      check("oe in shift", 80'h1, oeAll);
      host_u.finish(oe);
      check("oe after shift", 80'h0, oe);
      $display("test row %0d done", r);
    end
    // four highs from shift must not reset, the fifth must
    host_u.scan(1'b1, 3, 80'(`TAP_OP_SAMPLEZ), dout, oeAll);
    host_u.finish(oe);
    host_u.scan(1'b0, 0, DIN, dout, oeAll);
    repeat (4) host_u.step(1'b1, 1'b1, o, oe);
    repeat (4) @(negedge core_clk);
    check("hiz after four", 80'h1, memOutHiZ);
    host_u.step(1'b1, 1'b1, o, oe);
    repeat (4) @(negedge core_clk);
    check("hiz after five", 80'h0, memOutHiZ);
    $display("test tap reset done");
    // mode select stays high so the resync edge after reset stays in reset state
    rst_n = 1'b0;
    @(negedge core_clk);
    check("tdoOe in reset", 80'h0, tdoOe);
    rst_n = 1'b1;
    host_u.step(1'b0, 1'b1, o, oe);
    host_u.scan(1'b0, 80, DIN, dout, oeAll);
    check("id after reset", 80'(IDW) | (DIN << 32), dout);
    host_u.finish(oe);
    $display("test power reset done");
    host_u.scan(1'b1, 3, 80'(`TAP_OP_CAPTURE), dout, oeAll);
    repeat (4) @(negedge core_clk);
    check("hiz before update", 80'h0, memOutHiZ);
    host_u.finish(oe);
    repeat (4) @(negedge core_clk);
    check("hiz after update", 80'h1, memOutHiZ);
    $display("test update done");
    stop_test;
  end
endmodule  // testbench
